//--- hw/fpu_err_pkg.sv
package fpu_err_pkg;
  // Image sizes in bytes
  localparam int unsigned LEGACY16_IMAGE_BYTES = 94;
  localparam int unsigned LEGACY32_IMAGE_BYTES = 108;
  localparam int unsigned EXT_IMAGE_BYTES = 512;
  localparam int unsigned EXT_ALIGN_BYTES = 16;
  localparam int unsigned EXT_ALIGN_BITS = 4;
  // Control register zero field position
  localparam int unsigned NATIVE_ERROR_MODE_BIT_POS = 5;
  // Interrupt vectors
  localparam logic [7:0] NUMERIC_ERROR_VECTOR = 8'h10;
  localparam logic [7:0] DEVICE_UNAVAILABLE_VECTOR = 8'h07;
  localparam logic [7:0] GENERAL_PROTECTION_VECTOR = 8'h0D;
  // Status and control word fields
  localparam int unsigned EXC_FLAG_BITS = 6;
  localparam logic [15:0] CONTROL_WORD_INIT = 16'h037F;
  localparam logic [15:0] STATUS_WORD_INIT = 16'h0000;
  localparam logic [15:0] TAG_WORD_INIT = 16'hFFFF;
  localparam logic [7:0] EXT_TAG_INIT = 8'h00;
  // Brief error pulse length on a no-wait save
  localparam int unsigned NOWAIT_PULSE_NS = 50;
  localparam int unsigned CLOCK_PERIOD_NS = 25;
  localparam int unsigned NOWAIT_PULSE_CYCLES = (NOWAIT_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned BYTE_COUNT_BITS = 10;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_WAITING,
    OP_NOWAIT,
    OP_WAITING_SAVE,
    OP_NOWAIT_SAVE,
    OP_LEGACY_RESTORE,
    OP_EXT_SAVE,
    OP_EXT_RESTORE
  } op_kind_t;

  typedef struct packed {
    logic valid;
    op_kind_t kind;
    logic mode32;
    logic [31:0] address;
  } issue_t;

  typedef struct packed {
    logic [15:0] control_word;
    logic [15:0] status_word;
    logic [15:0] tag_word;
  } fpu_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] vector;
  } trap_t;

  typedef struct packed {
    logic valid;
    logic ext_layout;
    logic [BYTE_COUNT_BITS-1:0] byte_count;
    logic [31:0] address;
  } xfer_t;
endpackage

//--- hw/save_sizer.sv
`timescale 1ns/1ps
`default_nettype none
module save_sizer (
  input wire logic clock,
  input wire logic reset,
  input wire fpu_err_pkg::issue_t issue,
  output fpu_err_pkg::xfer_t xfer,
  output logic misaligned
);
  import fpu_err_pkg::*;

  logic is_ext;
  logic is_legacy;
  logic [BYTE_COUNT_BITS-1:0] count;

  always_comb begin
    is_ext = issue.kind == OP_EXT_SAVE || issue.kind == OP_EXT_RESTORE;
    is_legacy = issue.kind == OP_WAITING_SAVE || issue.kind == OP_NOWAIT_SAVE || issue.kind == OP_LEGACY_RESTORE;
    if (is_ext) begin
      count = BYTE_COUNT_BITS'(EXT_IMAGE_BYTES);
    end else if (issue.mode32) begin
      count = BYTE_COUNT_BITS'(LEGACY32_IMAGE_BYTES);
    end else begin
      count = BYTE_COUNT_BITS'(LEGACY16_IMAGE_BYTES);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      xfer <= '0;
      misaligned <= 1'b0;
    end else begin
      misaligned <= issue.valid && is_ext && (issue.address[EXT_ALIGN_BITS-1:0] != '0);
      xfer.valid <= issue.valid && (is_legacy || (is_ext && issue.address[EXT_ALIGN_BITS-1:0] == '0));
      xfer.ext_layout <= is_ext;
      xfer.byte_count <= count;
      xfer.address <= issue.address;
    end
  end
endmodule
`default_nettype wire

//--- hw/pulse_stretch.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_stretch #(
  parameter int unsigned CYCLES = 2
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic start,
  output logic active
);
  logic [7:0] count_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      count_reg <= 8'h00;
    end else if (start) begin
      count_reg <= 8'(CYCLES);
    end else if (count_reg != 8'h00) begin
      count_reg <= count_reg - 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      active <= 1'b0;
    end else begin
      active <= start || count_reg > 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- hw/fpu_error_signalling.sv
// Functional notes
// - Legacy image 94 or 108 bytes
// - Extended image is 512 bytes
// - Extended image needs 16-byte alignment
// - Extended image uses its own layout
// - Legacy saves reinitialise the unit
// - Extended save leaves state unchanged
// - Record exception, then assert error output
// - Error sampled before waiting op, vector 16
// - No-wait ops run, exception stays pending except after a no-wait save
// - Native bit set selects internal reporting
// - Native mode latches and raises vector 16
// - Error output asserted in both modes
// - No-wait save pulses error when pending
// - No-wait ops trap in native only when unavailable
// - Native delivery has no external delay
// - Multiprocessor reporting only in native mode
// - Unavailable fault wins over numeric exception
`timescale 1ns/1ps
`default_nettype none
module fpu_error_signalling (
  input wire logic clock,
  input wire logic reset,
  input wire fpu_err_pkg::issue_t issue,
  input wire logic [fpu_err_pkg::EXC_FLAG_BITS-1:0] exc_raise,
  input wire logic [31:0] control_reg_zero,
  input wire logic device_unavailable,
  input wire logic multiprocessor,
  input wire logic legacy_error_sample,
  input wire fpu_err_pkg::fpu_state_t restore_state,
  output fpu_err_pkg::fpu_state_t fpu_state,
  output fpu_err_pkg::xfer_t xfer,
  output fpu_err_pkg::trap_t trap,
  output logic issue_accepted,
  output logic float_error_out_n,
  output logic legacy_float_irq_line,
  output logic [7:0] ext_tag_word
);
  import fpu_err_pkg::*;

  logic native_error_mode_bit;
  logic [EXC_FLAG_BITS-1:0] unmasked;
  logic pending;
  logic is_waiting;
  logic is_nowait;
  logic dna_hit;
  logic numeric_hit;
  logic nowait_save_go;
  logic pulse_active;
  logic misaligned;
  issue_t sizer_issue;
  logic [EXC_FLAG_BITS-1:0] flags_next;

  ////////////////////////////////////////////////////////////////
  // Mode and pending decode
  always_comb begin
    native_error_mode_bit = control_reg_zero[NATIVE_ERROR_MODE_BIT_POS] || multiprocessor;
    unmasked = fpu_state.status_word[EXC_FLAG_BITS-1:0] & ~fpu_state.control_word[EXC_FLAG_BITS-1:0];
    pending = unmasked != '0;
    is_waiting = issue.kind == OP_WAITING || issue.kind == OP_WAITING_SAVE
      || issue.kind == OP_LEGACY_RESTORE || issue.kind == OP_EXT_SAVE || issue.kind == OP_EXT_RESTORE;
    is_nowait = issue.kind == OP_NOWAIT || issue.kind == OP_NOWAIT_SAVE;
    dna_hit = issue.valid && (is_waiting || is_nowait) && device_unavailable;
    // Native traps internally; legacy only on the sampled external line
    numeric_hit = issue.valid && is_waiting && !device_unavailable
      && (native_error_mode_bit ? pending : legacy_error_sample);
    nowait_save_go = issue.valid && issue.kind == OP_NOWAIT_SAVE && !device_unavailable && pending;
    // Refused ops move no image
    sizer_issue = issue;
    sizer_issue.valid = issue.valid && !dna_hit && !numeric_hit;
    misaligned = issue.valid && (issue.kind == OP_EXT_SAVE || issue.kind == OP_EXT_RESTORE)
      && issue.address[EXT_ALIGN_BITS-1:0] != '0 && !dna_hit && !numeric_hit;
  end

  ////////////////////////////////////////////////////////////////
  // Trap delivery
  always_ff @(posedge clock) begin
    if (reset) begin
      trap <= '0;
      issue_accepted <= 1'b0;
    end else begin
      trap.valid <= dna_hit || numeric_hit || misaligned;
      if (dna_hit) begin
        trap.vector <= DEVICE_UNAVAILABLE_VECTOR;
      end else if (numeric_hit) begin
        trap.vector <= NUMERIC_ERROR_VECTOR;
      end else if (misaligned) begin
        trap.vector <= GENERAL_PROTECTION_VECTOR;
      end else begin
        trap.vector <= 8'h00;
      end
      issue_accepted <= issue.valid && !dna_hit && !numeric_hit;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Unit state
  always_comb begin
    flags_next = fpu_state.status_word[EXC_FLAG_BITS-1:0] | exc_raise;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      fpu_state.control_word <= CONTROL_WORD_INIT;
      fpu_state.status_word <= STATUS_WORD_INIT;
      fpu_state.tag_word <= TAG_WORD_INIT;
    end else if (issue.valid && !dna_hit && !numeric_hit
        && (issue.kind == OP_WAITING_SAVE || issue.kind == OP_NOWAIT_SAVE)) begin
      fpu_state.control_word <= CONTROL_WORD_INIT;
      fpu_state.status_word <= STATUS_WORD_INIT;
      fpu_state.tag_word <= TAG_WORD_INIT;
    end else if (issue.valid && !dna_hit && !numeric_hit && !misaligned
        && (issue.kind == OP_LEGACY_RESTORE || issue.kind == OP_EXT_RESTORE)) begin
      fpu_state <= restore_state;
    end else begin
      // Extended save leaves the state alone
      fpu_state.status_word[EXC_FLAG_BITS-1:0] <= flags_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Extended tag encoding, one bit per register
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_tag
      always_ff @(posedge clock) begin
        if (reset) begin
          ext_tag_word[i] <= EXT_TAG_INIT[i];
        end else begin
          ext_tag_word[i] <= fpu_state.tag_word[2*i+1 -: 2] != 2'b11;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Image transfer sizing
  save_sizer u_sizer (
    .clock(clock),
    .reset(reset),
    .issue(sizer_issue),
    .xfer(xfer),
    .misaligned()
  );

  ////////////////////////////////////////////////////////////////
  // Error output
  pulse_stretch #(
    .CYCLES(NOWAIT_PULSE_CYCLES)
  ) u_pulse (
    .clock(clock),
    .reset(reset),
    .start(nowait_save_go),
    .active(pulse_active)
  );

  always_ff @(posedge clock) begin
    if (reset) begin
      float_error_out_n <= 1'b1;
      legacy_float_irq_line <= 1'b0;
    end else begin
      float_error_out_n <= !(pending || pulse_active);
      legacy_float_irq_line <= !native_error_mode_bit && (pending || pulse_active);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Checks
  sequence waiting_pending_s;
    issue.valid && is_waiting && !device_unavailable && native_error_mode_bit && pending;
  endsequence

  property native_trap_p;
    @(posedge clock) disable iff (reset)
      waiting_pending_s |=> trap.valid && trap.vector == NUMERIC_ERROR_VECTOR;
  endproperty

  native_trap_a: assert property (native_trap_p) else $error("native numeric trap missing");

  nowait_no_trap_a: assert property (@(posedge clock) disable iff (reset)
    issue.valid && is_nowait && !device_unavailable |=> !trap.valid) else $error("no-wait op trapped");

  dna_first_a: assert property (@(posedge clock) disable iff (reset)
    issue.valid && is_waiting && device_unavailable && pending |=> trap.vector == DEVICE_UNAVAILABLE_VECTOR)
    else $error("unavailable fault not first");

  error_low_a: assert property (@(posedge clock) disable iff (reset)
    pending |=> !float_error_out_n) else $error("error output not low");

  nowait_pulse_a: assert property (@(posedge clock) disable iff (reset)
    nowait_save_go |=> ##1 !float_error_out_n [*2]) else $error("no-wait save pulse missing");

  legacy_init_a: assert property (@(posedge clock) disable iff (reset)
    issue.valid && issue.kind == OP_NOWAIT_SAVE && !device_unavailable
    |=> fpu_state.tag_word == TAG_WORD_INIT) else $error("legacy save did not reinit");

  ext_keep_a: assert property (@(posedge clock) disable iff (reset)
    issue.valid && issue.kind == OP_EXT_SAVE && !numeric_hit && !device_unavailable
    |=> fpu_state.control_word == $past(fpu_state.control_word)) else $error("extended save changed state");

  ext_size_a: assert property (@(posedge clock) disable iff (reset)
    xfer.valid && xfer.ext_layout |-> xfer.byte_count == 10'h200) else $error("extended size wrong");

  legacy_size_a: assert property (@(posedge clock) disable iff (reset)
    xfer.valid && !xfer.ext_layout |-> xfer.byte_count == 10'h05E || xfer.byte_count == 10'h06C)
    else $error("legacy size wrong");

  misalign_a: assert property (@(posedge clock) disable iff (reset)
    issue.valid && issue.kind == OP_EXT_SAVE && issue.address[3:0] != 4'h0 && !dna_hit && !numeric_hit
    |=> trap.valid && !xfer.valid) else $error("misaligned not faulted");
endmodule
`default_nettype wire

//--- test/irq_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic irq_enable,
  input wire logic irq_in,
  output logic sample_out
);
  // Masked error line handed back to the core one cycle late
  always_ff @(posedge clock) begin
    if (reset) begin
      sample_out <= 1'b0;
    end else begin
      sample_out <= irq_enable & irq_in;
    end
  end
endmodule
`default_nettype wire

//--- test/fpu_error_signalling_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module fpu_error_signalling_bench;
  import fpu_err_pkg::*;
  logic clock, reset, dev_unavail, multiproc, irq_en, les, accepted, err_n, irq_line;
  issue_t issue;
  logic [5:0] exc_raise;
  logic [31:0] cr0;
  fpu_state_t restore_state, fpu_state;
  xfer_t xfer;
  trap_t trap;
  logic [7:0] ext_tag;
  logic [15:0] cw, sw, tw;
  int compares, n_mismatch, seed;
  fpu_error_signalling dut (.clock(clock), .reset(reset), .issue(issue), .exc_raise(exc_raise),
    .control_reg_zero(cr0), .device_unavailable(dev_unavail), .multiprocessor(multiproc),
    .legacy_error_sample(les), .restore_state(restore_state), .fpu_state(fpu_state), .xfer(xfer),
    .trap(trap), .issue_accepted(accepted), .float_error_out_n(err_n),
    .legacy_float_irq_line(irq_line), .ext_tag_word(ext_tag));
  irq_ctrl_model pic (.clock(clock), .reset(reset), .irq_enable(irq_en), .irq_in(irq_line),
    .sample_out(les));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic pend();
    return (sw[5:0] & ~cw[5:0]) != 6'h00;
  endfunction
  function automatic logic [7:0] etag();
    logic [7:0] t;
    for (int i = 0; i < 8; i++) t[i] = tw[2*i +: 2] != 2'b11;
    return t;
  endfunction
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_state();
    `CHK("state", {cw, sw[5:0], tw}, {fpu_state.control_word, fpu_state.status_word[5:0], fpu_state.tag_word})
  endtask
  task automatic raise_exc(input logic [5:0] f);
    exc_raise = f;
    @(posedge clock);
    #1;
    exc_raise = 6'h00;
    sw[5:0] = sw[5:0] | f;
    repeat (3) @(posedge clock);
    #1;
    chk_state();
    `CHK("err_n", !pend(), err_n)
    `CHK("irq_line", pend() && !(cr0[5] | multiproc), irq_line)
  endtask
  task automatic do_op(input op_kind_t k, input logic m32, input logic [31:0] a);
    logic num, sv, rs, ex, xv;
    logic [7:0] v;
    num = (k == OP_WAITING || k == OP_WAITING_SAVE || k == OP_LEGACY_RESTORE || k == OP_EXT_SAVE
      || k == OP_EXT_RESTORE) && ((cr0[5] | multiproc) ? pend() : les);
    ex = (k == OP_EXT_SAVE || k == OP_EXT_RESTORE);
    sv = (k == OP_WAITING_SAVE || k == OP_NOWAIT_SAVE);
    rs = (k == OP_LEGACY_RESTORE || k == OP_EXT_RESTORE);
    v = dev_unavail ? 8'h07 : num ? 8'h10 : (ex && a[3:0] != 4'h0) ? 8'h0D : 8'h00;
    xv = (v == 8'h00) && (sv || rs || k == OP_EXT_SAVE);
    issue = '{1'b1, k, m32, a};
    @(posedge clock);
    #1;
    issue.valid = 1'b0;
    `CHK("trap_valid", v != 8'h00, trap.valid)
    if (v != 8'h00) `CHK("trap_vector", v, trap.vector)
    `CHK("accepted", v == 8'h00 || v == 8'h0D, accepted)
    `CHK("xfer_valid", xv, xfer.valid)
    if (xv) `CHK("bytes", 10'(ex ? 512 : m32 ? 108 : 94), xfer.byte_count)
    if (xv) `CHK("layout_addr", {ex, a}, {xfer.ext_layout, xfer.address})
    if (v == 8'h00 && sv) {cw, sw, tw} = {CONTROL_WORD_INIT, STATUS_WORD_INIT, TAG_WORD_INIT};
    if (v == 8'h00 && rs) {cw, sw, tw} = restore_state;
    chk_state();
    @(posedge clock);
    #1;
    `CHK("ext_tag", etag(), ext_tag)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    #(25 * 5000);
    n_mismatch++;
    complete_run();
  end
  initial begin
    reset = 1'b1;
    issue = '0;
    exc_raise = 6'h00;
    cr0 = 32'h0000_0020;
    {dev_unavail, multiproc, irq_en} = 3'b000;
    restore_state = '0;
    compares = 0;
    n_mismatch = 0;
    seed = 27356;
    {cw, sw, tw} = {CONTROL_WORD_INIT, STATUS_WORD_INIT, TAG_WORD_INIT};
    repeat (5) @(posedge clock);
    #1;
    reset = 1'b0;
    `CHK("err_n", 1'b1, err_n)
    for (int i = 0; i < 60; i++) begin
      restore_state = '{16'($random(seed)) | 16'h003F, 16'($random(seed)), 16'($random(seed))};
      dev_unavail = ($random(seed) & 7) == 0;
      do_op(op_kind_t'(3'(1 + {$random(seed)} % 7)), 1'($random(seed)),
        32'($random(seed)) & (i[0] ? 32'hFFFF_FFFF : 32'hFFFF_FFF0));
    end
    $display("random ops done");
    dev_unavail = 1'b0;
    restore_state = '{16'h0340, 16'h0000, 16'h5A5A};
    do_op(OP_LEGACY_RESTORE, 1'b1, 32'h0000_0100);
    raise_exc(6'h01);
    do_op(OP_NOWAIT, 1'b0, 32'h0);
    dev_unavail = 1'b1;
    do_op(OP_WAITING, 1'b0, 32'h0);
    dev_unavail = 1'b0;
    do_op(OP_WAITING, 1'b0, 32'h0);
    do_op(OP_NOWAIT_SAVE, 1'b1, 32'h0000_0300);
    `CHK("err_pulse", 1'b0, err_n)
    @(posedge clock);
    #1;
    `CHK("err_pulse", 1'b0, err_n)
    @(posedge clock);
    #1;
    `CHK("err_idle", 1'b1, err_n)
    do_op(OP_EXT_SAVE, 1'b1, 32'h0000_0600);
    do_op(OP_WAITING_SAVE, 1'b1, 32'h0000_0700);
    $display("native mode done");
    cr0 = 32'h0;
    irq_en = 1'b1;
    restore_state = '{16'h0340, 16'h0000, 16'hFFFF};
    do_op(OP_LEGACY_RESTORE, 1'b0, 32'h0000_0400);
    raise_exc(6'h04);
    do_op(OP_NOWAIT, 1'b0, 32'h0);
    do_op(OP_WAITING, 1'b0, 32'h0);
    irq_en = 1'b0;
    multiproc = 1'b1;
    raise_exc(6'h00);
    do_op(OP_WAITING, 1'b0, 32'h0);
    do_op(OP_WAITING_SAVE, 1'b0, 32'h0);
    do_op(OP_NOWAIT_SAVE, 1'b0, 32'h0000_0500);
    $display("legacy and multiprocessor done");
    complete_run();
  end
endmodule
`default_nettype wire
